// *** design/swf_bank_map.sv ***
// Working register address mapper for the selected bank
`include "sw_flags_params.svh"
module swf_bank_map
   import swf_pkg::*;
(
   input wire logic [1:0] bank_i, // Selected bank
   input wire logic [2:0] reg_i, // Working register number
   output logic [7:0] addr_o // Internal data memory address
);
   // Eight bytes per bank starting at eight times bank
   assign addr_o = {3'h0, bank_i, reg_i};
endmodule : swf_bank_map

// *** design/swf_flag_calc.sv ***
// Combinational carry and half-carry calculation for one arithmetic result
`include "sw_flags_params.svh"
module swf_flag_calc
   import swf_pkg::*;
(
   input wire logic [7:0] opa_i, // First operand
   input wire logic [7:0] opb_i, // Second operand
   input wire logic cin_i, // Carry or borrow in
   input wire logic sub_i, // High for subtraction
   output logic carry_o, // Carry out or borrow
   output logic half_o // Nibble carry or borrow
);
   logic [8:0] full_sum; // Nine bit result
   logic [4:0] low_sum; // Low nibble result
   ////////////////////////////////////////////////////////////////////////////
   // Add or subtract with borrow, both widths
   always_comb begin
      if (sub_i) begin
         full_sum = {1'b0, opa_i} - {1'b0, opb_i} - {8'h00, cin_i};
         low_sum = {1'b0, opa_i[3:0]} - {1'b0, opb_i[3:0]} - {4'h0, cin_i};
      end else begin
         full_sum = {1'b0, opa_i} + {1'b0, opb_i} + {8'h00, cin_i};
         low_sum = {1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]} + {4'h0, cin_i};
      end
   end
   // Top bit is carry out or borrow
   assign carry_o = full_sum[8];
   // Nibble carry into, or borrow from, the upper nibble
   assign half_o = low_sum[`SWF_NIBBLE_HI];
endmodule : swf_flag_calc

// *** design/swf_status_word.sv ***
// Status word register with arithmetic flag update and AXI4-Lite access
`include "sw_flags_params.svh"
module swf_status_word
   import swf_pkg::*;
(
   input wire logic clk_sys_i, // Core clock
   input wire logic rst_i, // Synchronous reset, high
   // Arithmetic unit side
   input wire logic alu_valid_i, // One-cycle operation strobe
   input wire swf_op_t alu_op_i, // Operation kind
   input wire logic [7:0] alu_opa_i, // First operand
   input wire logic [7:0] alu_opb_i, // Second operand
   input wire logic alu_use_carry_i, // Include stored carry as cin
   input wire logic [2:0] wreg_sel_i, // Working register number
   output logic [7:0] wreg_addr_o, // Mapped register address
   output logic [1:0] bank_sel_o, // Current bank
   output logic carry_flag_o, // Carry flag level
   output logic half_carry_flag_o, // Half-carry level
   output logic user_flag_zero_o, // User flag level
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] psw_q; // Status word
   logic [7:0] rsv_q; // Reserved scratch word at its own offset
   logic aw_held_q; // Write address captured
   logic w_held_q; // Write data captured
   logic [11:0] awaddr_q; // Captured write address
   logic [31:0] wdata_q; // Captured write data
   logic wstrb0_q; // Captured lane zero strobe
   swf_bus_st_t wr_st_q; // Write path state
   swf_bus_st_t rd_st_q; // Read path state
   logic [31:0] rdata_q; // Read data register
   logic [1:0] rresp_q; // Read response
   logic [1:0] bresp_q; // Write response
   logic calc_carry; // Carry from calculator
   logic calc_half; // Half-carry from calculator
   logic wr_fire; // Both write halves present
   logic psw_wr; // Software write to status word
   logic rsv_wr; // Software write to reserved word
   logic arith; // Arithmetic operation this cycle
   ////////////////////////////////////////////////////////////////////////////
   // Flag calculator
   swf_flag_calc u_calc (
      .opa_i(alu_opa_i),
      .opb_i(alu_opb_i),
      .cin_i(alu_use_carry_i & psw_q[`SWF_BIT_CARRY]),
      .sub_i(alu_op_i == SWF_OP_SUB),
      .carry_o(calc_carry),
      .half_o(calc_half)
   );
   // Bank address mapper
   swf_bank_map u_map (
      .bank_i(psw_q[`SWF_BIT_BANK_HI:`SWF_BIT_BANK_LO]),
      .reg_i(wreg_sel_i),
      .addr_o(wreg_addr_o)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Decode of strobes
   assign arith = alu_valid_i;
   assign wr_fire = aw_held_q & w_held_q & (wr_st_q == SWF_BUS_IDLE);
   assign psw_wr = wr_fire & wstrb0_q & (awaddr_q == `SWF_PSW_OFFSET);
   assign rsv_wr = wr_fire & wstrb0_q & (awaddr_q == `SWF_RSV_OFFSET);
   ////////////////////////////////////////////////////////////////////////////
   // Status word in one process so every bit has a single driver
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         psw_q <= `SWF_PSW_RESET;
      end else begin
         // Software owns user flag, bank select and low bits
         if (psw_wr) begin
            psw_q <= wdata_q[7:0];
         end
         // Arithmetic update wins for carry and half-carry
         if (arith) begin
            psw_q[`SWF_BIT_CARRY] <= (alu_op_i != SWF_OP_OTHER) & calc_carry;
            psw_q[`SWF_BIT_HALF] <= (alu_op_i != SWF_OP_OTHER) & calc_half;
         end
      end
   end
   // Reserved scratch word, resets to its default zero
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rsv_q <= `SWF_RSV_RESET;
      end else if (rsv_wr) begin
         rsv_q <= wdata_q[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Write channel capture, address and data in either order
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 12'h000;
      end else if (s_axi_awvalid_i & s_axi_awready_o) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr_i;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end
   // Write data capture
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
      end else if (s_axi_wvalid_i & s_axi_wready_o) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata_i;
         wstrb0_q <= s_axi_wstrb_i[0];
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end
   // Write response
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_st_q <= SWF_BUS_IDLE;
         bresp_q <= `SWF_RESP_OKAY;
      end else begin
         case (wr_st_q)
            SWF_BUS_IDLE: begin
               if (wr_fire) begin
                  wr_st_q <= SWF_BUS_RESP;
                  bresp_q <= (awaddr_q == `SWF_PSW_OFFSET || awaddr_q == `SWF_RSV_OFFSET)
                     ? `SWF_RESP_OKAY : `SWF_RESP_SLVERR;
               end
            end
            SWF_BUS_RESP: begin
               if (s_axi_bready_i) begin
                  wr_st_q <= SWF_BUS_IDLE;
               end
            end
            default: begin
               wr_st_q <= SWF_BUS_IDLE;
            end
         endcase
      end
   end
   assign s_axi_awready_o = ~aw_held_q & (wr_st_q == SWF_BUS_IDLE);
   assign s_axi_wready_o = ~w_held_q & (wr_st_q == SWF_BUS_IDLE);
   assign s_axi_bvalid_o = (wr_st_q == SWF_BUS_RESP);
   assign s_axi_bresp_o = bresp_q;
   ////////////////////////////////////////////////////////////////////////////
   // Read path, one cycle to answer
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rd_st_q <= SWF_BUS_IDLE;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `SWF_RESP_OKAY;
      end else begin
         case (rd_st_q)
            SWF_BUS_IDLE: begin
               if (s_axi_arvalid_i) begin
                  rd_st_q <= SWF_BUS_RESP;
                  // Upper bits read as zero
                  if (s_axi_araddr_i == `SWF_PSW_OFFSET) begin
                     rdata_q <= {24'h00_0000, psw_q};
                     rresp_q <= `SWF_RESP_OKAY;
                  end else if (s_axi_araddr_i == `SWF_RSV_OFFSET) begin
                     rdata_q <= {24'h00_0000, rsv_q};
                     rresp_q <= `SWF_RESP_OKAY;
                  end else begin
                     rdata_q <= 32'h0000_0000;
                     rresp_q <= `SWF_RESP_SLVERR;
                  end
               end
            end
            SWF_BUS_RESP: begin
               if (s_axi_rready_i) begin
                  rd_st_q <= SWF_BUS_IDLE;
               end
            end
            default: begin
               rd_st_q <= SWF_BUS_IDLE;
            end
         endcase
      end
   end
   assign s_axi_arready_o = (rd_st_q == SWF_BUS_IDLE);
   assign s_axi_rvalid_o = (rd_st_q == SWF_BUS_RESP);
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   ////////////////////////////////////////////////////////////////////////////
   // Flag levels out
   assign bank_sel_o = psw_q[`SWF_BIT_BANK_HI:`SWF_BIT_BANK_LO];
   assign carry_flag_o = psw_q[`SWF_BIT_CARRY];
   assign half_carry_flag_o = psw_q[`SWF_BIT_HALF];
   assign user_flag_zero_o = psw_q[`SWF_BIT_USER0];
endmodule : swf_status_word

// *** dv/swf_status_word_sva.sv ***
// Assertion checker for the status word block
module swf_status_word_sva
   import swf_pkg::*;
(
   input wire logic clk_sys_i, // Core clock
   input wire logic rst_i, // Synchronous reset, high
   input wire logic alu_valid_i, // Operation strobe
   input wire logic alu_use_carry_i, // Stored carry as input
   input wire swf_op_t alu_op_i, // Operation kind
   input wire logic [7:0] alu_opa_i, // First operand
   input wire logic [7:0] alu_opb_i, // Second operand
   input wire logic [7:0] wreg_addr_o, // Mapped register address
   input wire logic [2:0] wreg_sel_i, // Working register number
   input wire logic [1:0] bank_sel_o, // Current bank
   input wire logic carry_flag_o, // Carry level
   input wire logic half_carry_flag_o, // Half-carry level
   input wire logic user_flag_zero_o, // User flag level
   input wire logic s_axi_awvalid_i, // Write address valid
   input wire logic s_axi_awready_o, // Write address ready
   input wire logic s_axi_wvalid_i, // Write data valid
   input wire logic s_axi_wready_o, // Write data ready
   input wire logic s_axi_bvalid_o, // Write response valid
   input wire logic s_axi_bready_i, // Write response ready
   input wire logic s_axi_arvalid_i, // Read address valid
   input wire logic s_axi_arready_o, // Read address ready
   input wire logic s_axi_rvalid_o, // Read data valid
   input wire logic s_axi_rready_i // Read data ready
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic ci_w; // Stored carry used as input
   logic [8:0] r9_w; // Full result with carry
   logic [4:0] r5_w; // Low nibble result
   // Reference flags for the offered operation
   always_comb begin
      ci_w = alu_use_carry_i & carry_flag_o;
      if (alu_op_i == SWF_OP_SUB) begin
         r9_w = {1'b0, alu_opa_i} - {1'b0, alu_opb_i} - 9'(ci_w);
         r5_w = {1'b0, alu_opa_i[3:0]} - {1'b0, alu_opb_i[3:0]} - 5'(ci_w);
      end else begin
         r9_w = {1'b0, alu_opa_i} + {1'b0, alu_opb_i} + 9'(ci_w);
         r5_w = {1'b0, alu_opa_i[3:0]} + {1'b0, alu_opb_i[3:0]} + 5'(ci_w);
      end
   end
   wire arith_w = (alu_op_i == SWF_OP_ADD) || (alu_op_i == SWF_OP_SUB);
   chk_carry_upd: assert property (alu_valid_i |=>
      carry_flag_o == $past(arith_w & r9_w[8])) else $error("carry flag wrong");
   chk_half_upd: assert property (alu_valid_i |=>
      half_carry_flag_o == $past(arith_w & r5_w[4])) else $error("half carry wrong");
   chk_user_sw: assert property ($changed(user_flag_zero_o) |->
      $rose(s_axi_bvalid_o)) else $error("user flag changed without write");
   chk_bank_sw: assert property ($changed(bank_sel_o) |->
      $rose(s_axi_bvalid_o)) else $error("bank changed without write");
   chk_bank_addr: assert property (
      wreg_addr_o == (8'(bank_sel_o) * 8'h08 + 8'(wreg_sel_i)))
      else $error("register address wrong");
   chk_rst_zero: assert property (disable iff (1'b0) rst_i |=>
      !carry_flag_o && !half_carry_flag_o && !user_flag_zero_o && bank_sel_o == 2'b00)
      else $error("status word not cleared");
   chk_wr_resp: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
   chk_rd_resp: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read response late");
   chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write response dropped");
   chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
      else $error("read response dropped");
   cover property (alu_valid_i && alu_op_i == SWF_OP_SUB);
   cover property ($rose(s_axi_bvalid_o));
   cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule : swf_status_word_sva
bind swf_status_word swf_status_word_sva u_sva (.*);

// *** dv/swf_status_word_tb.sv ***
// Self-checking testbench for the status word block
`include "sw_flags_params.svh"
module swf_status_word_tb
   import swf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, alu_valid_i = 1'b0, alu_use_carry_i = 1'b0;
   swf_op_t alu_op_i = SWF_OP_ADD;
   logic [7:0] alu_opa_i = 8'h00, alu_opb_i = 8'h00, wreg_addr_o;
   logic [2:0] wreg_sel_i = 3'h0;
   logic [1:0] bank_sel_o, s_axi_bresp_o, s_axi_rresp_o;
   logic carry_flag_o, half_carry_flag_o, user_flag_zero_o;
   logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i = 4'h0;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   logic ecy = 1'b0, ehc = 1'b0; // Expected arithmetic flags
   swf_status_word dut (.*);
   always #20 clk_sys_i = ~clk_sys_i;
   // Hang guard
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   task cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   // Bus write, each channel released once taken
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge clk_sys_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o);
      s_axi_bready_i <= 1'b0;
      cmp(32'(s_axi_bresp_o), 32'(er));
   endtask : wr
   // Bus read and compare
   task rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk_sys_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o);
      s_axi_rready_i <= 1'b0;
      cmp(s_axi_rdata_o, e);
      cmp(32'(s_axi_rresp_o), 32'(er));
   endtask : rdc
   // One arithmetic strobe, flags checked the cycle after
   task alu(input swf_op_t op, input logic [7:0] a, input logic [7:0] b, input logic uc);
      logic [8:0] r9;
      logic [4:0] r5;
      logic ci;
      ci = uc & ecy;
      if (op == SWF_OP_SUB) begin
         r9 = {1'b0, a} - {1'b0, b} - 9'(ci);
         r5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(ci);
      end else begin
         r9 = {1'b0, a} + {1'b0, b} + 9'(ci);
         r5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
      end
      ecy = (op != SWF_OP_OTHER) & r9[8];
      ehc = (op != SWF_OP_OTHER) & r5[4];
      @(posedge clk_sys_i);
      alu_op_i <= op;
      alu_opa_i <= a;
      alu_opb_i <= b;
      alu_use_carry_i <= uc;
      alu_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      alu_valid_i <= 1'b0;
      @(posedge clk_sys_i);
      cmp({30'h0, carry_flag_o, half_carry_flag_o}, {30'h0, ecy, ehc});
   endtask : alu
   task t_reset;
      rdc(`SWF_PSW_OFFSET, 32'h0, `SWF_RESP_OKAY);
      rdc(`SWF_RSV_OFFSET, 32'h0, `SWF_RESP_OKAY);
      $display("reset test done");
   endtask : t_reset
   task t_flags;
      alu(SWF_OP_ADD, 8'h0f, 8'h01, 1'b0);
      alu(SWF_OP_ADD, 8'hf0, 8'h10, 1'b0);
      alu(SWF_OP_ADD, 8'hff, 8'h00, 1'b1);
      alu(SWF_OP_SUB, 8'h10, 8'h01, 1'b1);
      alu(SWF_OP_SUB, 8'h00, 8'h01, 1'b0);
      rdc(`SWF_PSW_OFFSET, 32'hc0, `SWF_RESP_OKAY);
      alu(SWF_OP_OTHER, 8'hff, 8'hff, 1'b1);
      $display("flag test done");
   endtask : t_flags
   task t_bank;
      for (int n = 0; n < 4; n++) begin
         wr(`SWF_PSW_OFFSET, {24'h0, 3'b001, 2'(n), 3'h0}, 4'h1, `SWF_RESP_OKAY);
         wreg_sel_i <= 3'h5;
         alu(SWF_OP_ADD, 8'hff, 8'h01, 1'b0);
         cmp({24'h0, wreg_addr_o}, 32'(n * 8 + 5));
         cmp({29'h0, user_flag_zero_o, bank_sel_o}, {29'h0, 1'b1, 2'(n)});
      end
      wr(`SWF_PSW_OFFSET, 32'h0, 4'h1, `SWF_RESP_OKAY);
      cmp({31'h0, user_flag_zero_o}, 32'h0);
      $display("bank test done");
   endtask : t_bank
   task t_bus;
      wr(`SWF_PSW_OFFSET, 32'h18, 4'h0, `SWF_RESP_OKAY);
      wr(12'h100, 32'hff, 4'hf, `SWF_RESP_SLVERR);
      rdc(12'h100, 32'h0, `SWF_RESP_SLVERR);
      rdc(`SWF_PSW_OFFSET, 32'h0, `SWF_RESP_OKAY);
      wr(`SWF_RSV_OFFSET, 32'h0, 4'hf, `SWF_RESP_OKAY);
      rdc(`SWF_RSV_OFFSET, 32'h0, `SWF_RESP_OKAY);
      $display("bus test done");
   endtask : t_bus
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset();
      t_flags();
      t_bank();
      t_bus();
      conclude();
   end
endmodule : swf_status_word_tb

// *** shared/sw_flags_params.svh ***
// Register offsets, field positions and reset values of the status word block
//
// Behaviour
// - Carry flag: set on carry/borrow, else cleared
// - Half-carry flag: nibble carry/borrow, else cleared
// - User flag zero changes only by software
// - Bank select field picks working register bank
// - Reserved bits reset zero, zero means default
`ifndef SW_FLAGS_PARAMS_SVH
`define SW_FLAGS_PARAMS_SVH
`define SWF_PSW_OFFSET 12'h0d0
`define SWF_RSV_OFFSET 12'h0d4
`define SWF_PSW_RESET 8'h00
`define SWF_RSV_RESET 8'h00
`define SWF_BIT_CARRY 7
`define SWF_BIT_HALF 6
`define SWF_BIT_USER0 5
`define SWF_BIT_BANK_HI 4
`define SWF_BIT_BANK_LO 3
`define SWF_BANK_SHIFT 3
`define SWF_NIBBLE_HI 4
`define SWF_RESP_OKAY 2'b00
`define SWF_RESP_SLVERR 2'b10
`endif

// *** shared/swf_pkg.sv ***
// Types shared by the status word block
package swf_pkg;
   // Arithmetic operation kinds offered by the core
   typedef enum logic [1:0] {
      SWF_OP_ADD,
      SWF_OP_SUB,
      SWF_OP_OTHER
   } swf_op_t;
   // Bus slave states
   typedef enum logic [1:0] {
      SWF_BUS_IDLE,
      SWF_BUS_RESP
   } swf_bus_st_t;
endpackage : swf_pkg
